/* act_cal_test_regs.sv */
// Calibration control, status and output test register bank of the converter.
`include "act_cal_regs.svh"

//Contract
//- With the test pattern select bit set, the output path carries the built-in test pattern instead of samples.
//- With the over-range enable bit set the over-range output follows the converter, otherwise it stays low.
//- While scan access is enabled, each read of the vector port returns the next stored calibration value.
//- While scan access is enabled, each write of the vector port loads the next calibration value.
//- The halted flag reads 0 while any calibration runs and 1 once it has finished or stopped.
//- Status bit 0 sets once the first full calibration after startup completes, and the status register is read-only.
//- Bit 0 of the timing calibration register enables automatic timing optimisation within calibration.
//- The timing bit starts nothing alone; timing calibration runs only with the next foreground trigger.
//- Setting the foreground trigger starts a foreground calibration and clears itself.
//- Only while the scan enable bit is set may the vector port read or load calibration vectors.
//- The background run bit stops the background sequence when 0 and starts it when 1.
module act_cal_test_regs (
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    input  wire act_pkg::act_addr_t    cfgAddr,
    input  wire logic                  cfgWrite,
    input  wire logic                  cfgRead,
    input  wire act_pkg::act_byte_t    cfgWdata,
    output act_pkg::act_byte_t         cfgRdata,
    input  wire logic                  calRunning,
    input  wire logic                  calSeqDone,
    input  wire logic                  vecEngWrite,
    input  wire act_pkg::act_vec_idx_t vecEngIdx,
    input  wire act_pkg::act_byte_t    vecEngData,
    input  wire act_pkg::act_vec_idx_t vecEngRdIdx,
    output act_pkg::act_byte_t         vecEngRdData,
    input  wire act_pkg::act_sample_t  convSample,
    input  wire logic                  overRangeIn,
    output act_pkg::act_sample_t       sampleOut,
    output logic                       overRangeOut,
    output logic                       fgCalStart,
    output logic                       timingCalGo,
    output logic                       timingAutoEn,
    output logic                       bgRun,
    output logic                       bgMode
);
    import act_pkg::*;

    act_byte_t   cfg0_ff;
    act_byte_t   nxt_cfg0;
    act_byte_t   back_ff;
    act_byte_t   nxt_back;
    act_byte_t   patOvr_ff;
    act_byte_t   nxt_patOvr;
    act_byte_t   vecHold_ff;
    act_byte_t   nxt_vecHold;
    act_byte_t   tcal_ff;
    act_byte_t   nxt_tcal;
    act_byte_t   rdData_ff;
    act_byte_t   nxt_rdData;
    logic        fgStart_ff;
    logic        nxt_fgStart;
    logic        timingGo_ff;
    logic        nxt_timingGo;
    logic        fgPending_ff;
    logic        nxt_fgPending;
    logic        firstDone_ff;
    logic        nxt_firstDone;
    act_byte_t   engRd_ff;
    act_byte_t   nxt_engRd;
    act_sample_t ramp_ff;
    act_sample_t nxt_ramp;
    act_sample_t sample_ff;
    act_sample_t nxt_sample;
    logic        ovr_ff;
    logic        nxt_ovr;

    logic        scanEn;
    logic        vecSel;
    logic        trigWrite;
    logic        calHalted;
    act_byte_t   statusWord;
    act_byte_t   scanRdata;
    act_byte_t   engRdata;

    assign scanEn    = cfg0_ff[`ACT_CFG0_SCAN];
    assign vecSel    = (cfgAddr == `ACT_ADDR_VEC);
    assign trigWrite = cfgWrite && (cfgAddr == `ACT_ADDR_CFG0) && cfgWdata[`ACT_CFG0_TRIG];

    act_vector_store u_vec (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .scanEn    (scanEn),
        .scanWrite (cfgWrite && vecSel),
        .scanRead  (cfgRead && vecSel),
        .scanWdata (cfgWdata),
        .scanRdata (scanRdata),
        .engWrite  (vecEngWrite),
        .engIdx    (vecEngIdx),
        .engWdata  (vecEngData),
        .engRdIdx  (vecEngRdIdx),
        .engRdata  (engRdata)
    );

    // A trigger that has not yet been seen by the engine already counts as running, so the
    // halted flag cannot read 1 in the gap between the trigger and the engine's busy level.
    assign calHalted = !calRunning && !fgPending_ff;

    always_comb begin
        statusWord                  = `ACT_STAT_RSVD;
        statusWord[`ACT_STAT_HALT]  = calHalted;
        statusWord[`ACT_STAT_FIRST] = firstDone_ff;
    end

    // Register writes and the read mux.
    always_comb begin
        nxt_cfg0    = cfg0_ff;
        nxt_back    = back_ff;
        nxt_patOvr  = patOvr_ff;
        nxt_vecHold = vecHold_ff;
        nxt_tcal    = tcal_ff;
        nxt_rdData  = rdData_ff;
        if (cfgWrite) begin
            case (cfgAddr)
                `ACT_ADDR_CFG0: begin
                    nxt_cfg0                = cfgWdata;
                    nxt_cfg0[`ACT_CFG0_TRIG] = 1'b0;
                end
                `ACT_ADDR_BACK:   nxt_back   = cfgWdata;
                `ACT_ADDR_PATOVR: nxt_patOvr = cfgWdata;
                `ACT_ADDR_TCAL:   nxt_tcal   = cfgWdata;
                `ACT_ADDR_VEC: begin
                    if (!scanEn) begin
                        nxt_vecHold = cfgWdata;
                    end
                end
                default: begin
                end
            endcase
        end
        if (cfgRead) begin
            case (cfgAddr)
                `ACT_ADDR_CFG0:   nxt_rdData = cfg0_ff;
                `ACT_ADDR_BACK:   nxt_rdData = back_ff;
                `ACT_ADDR_PATOVR: nxt_rdData = patOvr_ff;
                `ACT_ADDR_VEC:    nxt_rdData = scanEn ? scanRdata : vecHold_ff;
                `ACT_ADDR_STAT:   nxt_rdData = statusWord;
                `ACT_ADDR_TCAL:   nxt_rdData = tcal_ff;
                default:          nxt_rdData = `ACT_RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg0_ff    <= `ACT_RST_CFG0;
            back_ff    <= `ACT_RST_BACK;
            patOvr_ff  <= `ACT_RST_PATOVR;
            vecHold_ff <= `ACT_RST_VEC;
            tcal_ff    <= `ACT_RST_TCAL;
            rdData_ff  <= `ACT_RD_ZERO;
        end else begin
            cfg0_ff    <= nxt_cfg0;
            back_ff    <= nxt_back;
            patOvr_ff  <= nxt_patOvr;
            vecHold_ff <= nxt_vecHold;
            tcal_ff    <= nxt_tcal;
            rdData_ff  <= nxt_rdData;
        end
    end

    // Calibration engine handshake.
    always_comb begin
        nxt_fgStart   = trigWrite;
        nxt_timingGo  = trigWrite && tcal_ff[`ACT_TCAL_AUTO];
        nxt_fgPending = fgPending_ff;
        if (trigWrite) begin
            nxt_fgPending = 1'b1;
        end else if (calRunning || calSeqDone) begin
            nxt_fgPending = 1'b0;
        end
        nxt_firstDone = firstDone_ff || calSeqDone;
        nxt_engRd     = engRdata;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fgStart_ff   <= 1'b0;
            timingGo_ff  <= 1'b0;
            fgPending_ff <= 1'b0;
            firstDone_ff <= 1'b0;
            engRd_ff     <= `ACT_RST_VEC;
        end else begin
            fgStart_ff   <= nxt_fgStart;
            timingGo_ff  <= nxt_timingGo;
            fgPending_ff <= nxt_fgPending;
            firstDone_ff <= nxt_firstDone;
            engRd_ff     <= nxt_engRd;
        end
    end

    // Output path: the ramp restarts from zero each time the pattern is enabled, so a
    // capture always sees a known first word.
    always_comb begin
        nxt_ramp   = `ACT_SMP_ZERO;
        nxt_sample = convSample;
        if (patOvr_ff[`ACT_PAT_TEST]) begin
            nxt_ramp   = ramp_ff + `ACT_SMP_ONE;
            nxt_sample = ramp_ff;
        end
        nxt_ovr = patOvr_ff[`ACT_PAT_OVR] && overRangeIn;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ramp_ff   <= `ACT_SMP_ZERO;
            sample_ff <= `ACT_SMP_ZERO;
            ovr_ff    <= 1'b0;
        end else begin
            ramp_ff   <= nxt_ramp;
            sample_ff <= nxt_sample;
            ovr_ff    <= nxt_ovr;
        end
    end

    assign cfgRdata     = rdData_ff;
    assign vecEngRdData = engRd_ff;
    assign sampleOut    = sample_ff;
    assign overRangeOut = ovr_ff;
    assign fgCalStart   = fgStart_ff;
    assign timingCalGo  = timingGo_ff;
    assign timingAutoEn = tcal_ff[`ACT_TCAL_AUTO];
    assign bgRun        = back_ff[`ACT_BACK_RUN];
    assign bgMode       = back_ff[`ACT_BACK_MODE];
endmodule : act_cal_test_regs

/* act_cal_regs.svh */
// Register offsets, field positions and reset values of the calibration and test register bank.
`ifndef ACT_CAL_REGS_SVH
`define ACT_CAL_REGS_SVH

`define ACT_ADDR_CFG0       12'h050
`define ACT_ADDR_BACK       12'h057
`define ACT_ADDR_PATOVR     12'h058
`define ACT_ADDR_VEC        12'h05a
`define ACT_ADDR_STAT       12'h05b
`define ACT_ADDR_TCAL       12'h066

`define ACT_RST_CFG0        8'h06
`define ACT_RST_BACK        8'h10
`define ACT_RST_PATOVR      8'h00
`define ACT_RST_VEC         8'h00
`define ACT_RST_TCAL        8'h02
`define ACT_STAT_RSVD       8'h08
`define ACT_RD_ZERO         8'h00

`define ACT_CFG0_TRIG       3
`define ACT_CFG0_SCAN       4
`define ACT_BACK_MODE       0
`define ACT_BACK_RUN        1
`define ACT_PAT_OVR         1
`define ACT_PAT_TEST        2
`define ACT_TCAL_AUTO       0
`define ACT_STAT_FIRST      0
`define ACT_STAT_HALT       1

`define ACT_VEC_DEPTH       16
`define ACT_VEC_IDX_W       4
`define ACT_IDX_ZERO        4'h0
`define ACT_IDX_ONE         4'h1
`define ACT_SMP_ZERO        12'h000
`define ACT_SMP_ONE         12'h001

`endif

/* act_pkg.sv */
// Types shared by the calibration and test register bank.
package act_pkg;
    typedef logic [7:0]  act_byte_t;
    typedef logic [11:0] act_addr_t;
    typedef logic [11:0] act_sample_t;
    typedef logic [3:0]  act_vec_idx_t;
endpackage : act_pkg

/* act_vector_store.sv */
// Calibration vector storage with a scan pointer for streamed host access.
`include "act_cal_regs.svh"

module act_vector_store (
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 scanEn,
    input  wire logic                 scanWrite,
    input  wire logic                 scanRead,
    input  wire act_pkg::act_byte_t   scanWdata,
    output act_pkg::act_byte_t        scanRdata,
    input  wire logic                 engWrite,
    input  wire act_pkg::act_vec_idx_t engIdx,
    input  wire act_pkg::act_byte_t   engWdata,
    input  wire act_pkg::act_vec_idx_t engRdIdx,
    output act_pkg::act_byte_t        engRdata
);
    import act_pkg::*;

    act_byte_t    vecMem_ff [`ACT_VEC_DEPTH];
    act_byte_t    nxt_vecMem [`ACT_VEC_DEPTH];
    act_vec_idx_t scanPtr_ff;
    act_vec_idx_t nxt_scanPtr;
    logic         scanEnPrev_ff;
    logic         nxt_scanEnPrev;
    act_vec_idx_t scanIdx;

    // A change of the enable restarts the stream at once, so an access in the very next
    // cycle already uses the first slot instead of a stale pointer.
    assign scanIdx = (scanEn != scanEnPrev_ff) ? `ACT_IDX_ZERO : scanPtr_ff;

    always_comb begin
        nxt_vecMem     = vecMem_ff;
        nxt_scanPtr    = scanIdx;
        nxt_scanEnPrev = scanEn;
        if (engWrite) begin
            nxt_vecMem[engIdx] = engWdata;
        end
        // A host write to the same slot overrides the engine, the host restore is the deliberate one.
        if (scanEn && scanWrite) begin
            nxt_vecMem[scanIdx] = scanWdata;
        end
        if (scanEn && (scanWrite || scanRead)) begin
            nxt_scanPtr = scanIdx + `ACT_IDX_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < `ACT_VEC_DEPTH; i++) begin
                vecMem_ff[i] <= `ACT_RST_VEC;
            end
            scanPtr_ff    <= `ACT_IDX_ZERO;
            scanEnPrev_ff <= 1'b0;
        end else begin
            vecMem_ff     <= nxt_vecMem;
            scanPtr_ff    <= nxt_scanPtr;
            scanEnPrev_ff <= nxt_scanEnPrev;
        end
    end

    assign scanRdata = vecMem_ff[scanIdx];
    assign engRdata  = vecMem_ff[engRdIdx];
endmodule : act_vector_store

/* act_cal_test_regs_chk.sv */
// Concurrent checks on the ports of the calibration and test register bank.
`include "act_cal_regs.svh"

module act_cal_test_regs_chk (
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    input wire act_pkg::act_addr_t cfgAddr,
    input wire logic               cfgWrite,
    input wire logic               cfgRead,
    input wire act_pkg::act_byte_t cfgWdata,
    input wire act_pkg::act_byte_t cfgRdata,
    input wire logic               overRangeIn,
    input wire logic               overRangeOut,
    input wire logic               fgCalStart,
    input wire logic               timingCalGo,
    input wire logic               timingAutoEn,
    input wire logic               bgRun,
    input wire logic               bgMode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence trigWr;
        cfgWrite && cfgAddr == `ACT_ADDR_CFG0 && cfgWdata[`ACT_CFG0_TRIG];
    endsequence
    sequence onePulse;
        fgCalStart ##1 !fgCalStart;
    endsequence
    trig_start_a: assert property (trigWr |=> onePulse) else $error("no single start pulse");
    start_cause_a: assert property (fgCalStart |->
        $past(cfgWrite && cfgAddr == `ACT_ADDR_CFG0 && cfgWdata[`ACT_CFG0_TRIG]))
        else $error("start pulse without trigger write");
    timing_go_a: assert property (timingCalGo == (fgCalStart && timingAutoEn)) else $error("timing pulse wrong");
    tauto_wr_a: assert property (cfgWrite && cfgAddr == `ACT_ADDR_TCAL |->
        ##1 timingAutoEn == $past(cfgWdata[`ACT_TCAL_AUTO]))
        else $error("timing auto bit not written");
    bgrun_wr_a: assert property (cfgWrite && cfgAddr == `ACT_ADDR_BACK |->
        ##1 bgRun == $past(cfgWdata[`ACT_BACK_RUN]))
        else $error("background run bit not written");
    ovr_gate_a: assert property (!$past(overRangeIn) |-> !overRangeOut) else $error("over-range without cause");
    rdata_hold_a: assert property (!$past(cfgRead) && !$past(sys_rst) |-> $stable(cfgRdata))
        else $error("read data moved without read");
    stat_rsvd_a: assert property (cfgRead && cfgAddr == `ACT_ADDR_STAT |=> cfgRdata[7:2] == 6'h02)
        else $error("status upper bits wrong");
endmodule : act_cal_test_regs_chk

bind act_cal_test_regs act_cal_test_regs_chk act_cal_test_regs_chk_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cfgAddr(cfgAddr), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .overRangeIn(overRangeIn), .overRangeOut(overRangeOut),
    .fgCalStart(fgCalStart), .timingCalGo(timingCalGo), .timingAutoEn(timingAutoEn), .bgRun(bgRun), .bgMode(bgMode));

/* act_cal_test_regs_tb.sv */
// Self-checking testbench of the calibration and test register bank.
`include "act_cal_regs.svh"
`define TB_CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module act_cal_test_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import act_pkg::*;
    logic         ref_clk, sys_rst, cfgWrite, cfgRead, calRunning, calSeqDone, vecEngWrite, overRangeIn;
    logic         overRangeOut, fgCalStart, timingCalGo, timingAutoEn, bgRun, bgMode;
    act_addr_t    cfgAddr;
    act_byte_t    cfgWdata, cfgRdata, vecEngData, vecEngRdData;
    act_vec_idx_t vecEngIdx, vecEngRdIdx;
    act_sample_t  convSample, sampleOut;
    int           miscompares, nCompared, cycles;

    act_cal_test_regs act_cal_test_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfgAddr(cfgAddr),
        .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
        .calRunning(calRunning), .calSeqDone(calSeqDone), .vecEngWrite(vecEngWrite), .vecEngIdx(vecEngIdx),
        .vecEngData(vecEngData), .vecEngRdIdx(vecEngRdIdx), .vecEngRdData(vecEngRdData),
        .convSample(convSample), .overRangeIn(overRangeIn), .sampleOut(sampleOut), .overRangeOut(overRangeOut),
        .fgCalStart(fgCalStart), .timingCalGo(timingCalGo), .timingAutoEn(timingAutoEn), .bgRun(bgRun),
        .bgMode(bgMode));

    task automatic tick(); @(negedge ref_clk); endtask : tick
    // The idle cycle after each access keeps a strobe from being driven twice in one time step.
    task automatic wr(input act_addr_t a, input act_byte_t d);
        cfgAddr = a; cfgWdata = d; cfgWrite = 1'b1; tick(); cfgWrite = 1'b0; tick();
    endtask : wr
    task automatic rd(input act_addr_t a, input act_byte_t e);
        cfgAddr = a; cfgRead = 1'b1; tick(); cfgRead = 1'b0; `TB_CHK(cfgRdata, e) tick();
    endtask : rd
    task automatic pulseDone(); calSeqDone = 1'b1; tick(); calSeqDone = 1'b0; endtask : pulseDone

    task automatic test_reset();
        rd(`ACT_ADDR_CFG0, 8'h06);
        rd(`ACT_ADDR_BACK, 8'h10);
        rd(`ACT_ADDR_PATOVR, 8'h00);
        rd(`ACT_ADDR_VEC, 8'h00);
        rd(`ACT_ADDR_TCAL, 8'h02);
        rd(12'h100, 8'h00);
    endtask : test_reset
    task automatic test_status();
        rd(`ACT_ADDR_STAT, 8'h0a);
        wr(`ACT_ADDR_STAT, 8'hff);
        rd(`ACT_ADDR_STAT, 8'h0a);
        pulseDone();
        rd(`ACT_ADDR_STAT, 8'h0b);
        calRunning = 1'b1;
        rd(`ACT_ADDR_STAT, 8'h09);
        calRunning = 1'b0;
        tick();
    endtask : test_status
    task automatic test_trigger();
        wr(`ACT_ADDR_TCAL, 8'h03);
        `TB_CHK(timingAutoEn, 1'b1)
        `TB_CHK(fgCalStart, 1'b0)
        for (int t = 0; t < 2; t++) begin
            cfgAddr = `ACT_ADDR_CFG0; cfgWdata = 8'h0e; cfgWrite = 1'b1; tick(); cfgWrite = 1'b0;
            `TB_CHK(fgCalStart, 1'b1)
            `TB_CHK(timingCalGo, (t == 0))
            tick();
            `TB_CHK(fgCalStart, 1'b0)
            rd(`ACT_ADDR_STAT, 8'h09);
            rd(`ACT_ADDR_CFG0, 8'h06);
            pulseDone();
            rd(`ACT_ADDR_STAT, 8'h0b);
            wr(`ACT_ADDR_TCAL, 8'h02);
        end
    endtask : test_trigger
    task automatic test_scan();
        wr(`ACT_ADDR_CFG0, 8'h16);
        for (int i = 0; i < 16; i++) wr(`ACT_ADDR_VEC, 8'(8'h30 + i));
        wr(`ACT_ADDR_CFG0, 8'h06);
        wr(`ACT_ADDR_VEC, 8'h5a);
        rd(`ACT_ADDR_VEC, 8'h5a);
        vecEngRdIdx = 4'h0; tick();
        `TB_CHK(vecEngRdData, 8'h30)
        vecEngRdIdx = 4'h5; tick();
        `TB_CHK(vecEngRdData, 8'h35)
        vecEngWrite = 1'b1; vecEngIdx = 4'h2; vecEngData = 8'hc2; tick(); vecEngWrite = 1'b0;
        wr(`ACT_ADDR_CFG0, 8'h16);
        for (int i = 0; i < 17; i++) rd(`ACT_ADDR_VEC, (i == 2) ? 8'hc2 : 8'(8'h30 + i % 16));
        wr(`ACT_ADDR_CFG0, 8'h06);
    endtask : test_scan
    task automatic test_datapath();
        convSample = 12'h123; overRangeIn = 1'b1; tick();
        `TB_CHK(sampleOut, 12'h123)
        `TB_CHK(overRangeOut, 1'b0)
        wr(`ACT_ADDR_PATOVR, 8'h02);
        `TB_CHK(overRangeOut, 1'b1)
        wr(`ACT_ADDR_PATOVR, 8'h04);
        `TB_CHK(sampleOut, 12'h000)
        tick();
        `TB_CHK(sampleOut, 12'h001)
        `TB_CHK(overRangeOut, 1'b0)
        wr(`ACT_ADDR_PATOVR, 8'h00);
        `TB_CHK(sampleOut, 12'h123)
    endtask : test_datapath
    task automatic test_background();
        wr(`ACT_ADDR_BACK, 8'h13);
        `TB_CHK(bgRun, 1'b1)
        `TB_CHK(bgMode, 1'b1)
        rd(`ACT_ADDR_BACK, 8'h13);
        calRunning = 1'b1;
        wr(`ACT_ADDR_BACK, 8'h11);
        `TB_CHK(bgRun, 1'b0)
        // The engine winds down after the run bit clears: halted reads 0 while calRunning stays high and 1 once it drops.
        rd(`ACT_ADDR_STAT, 8'h09);
        calRunning = 1'b0;
        rd(`ACT_ADDR_STAT, 8'h0b);
    endtask : test_background

    task automatic summarize();
        $display("compared %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        sys_rst = 1'b1; cfgWrite = 1'b0; cfgRead = 1'b0; cfgAddr = 12'h000; cfgWdata = 8'h00;
        calRunning = 1'b0; calSeqDone = 1'b0; vecEngWrite = 1'b0; vecEngIdx = 4'h0; vecEngData = 8'h00;
        vecEngRdIdx = 4'h0; convSample = 12'h000; overRangeIn = 1'b0;
        repeat (6) tick();
        sys_rst = 1'b0;
        test_reset();
        test_status();
        test_trigger();
        test_scan();
        test_datapath();
        test_background();
        summarize();
    end
endmodule : act_cal_test_regs_tb
